// ==== hdl/adi_pkg.sv ====
/*
 * Shared constants of the analog-die interrupt aggregator: register
 * offsets, address windows, source bit positions and reset values.
 * Assumes a single system clock and an 8-bit register port on the
 * die-to-die link.
 */
package adi_pkg;

    // ========================================================
    // Widths
    localparam int ADI_NSRC = 14;
    localparam int ADI_AW = 16;
    localparam int ADI_DW = 8;
    localparam int ADI_VW = 5;

    // ========================================================
    // Address windows (upper byte of the global address)
    localparam logic [7:0] ADI_BASE_BLOCKING = 8'h0E;
    localparam logic [7:0] ADI_BASE_NONBLOCKING = 8'h0F;

    // ========================================================
    // Register offsets
    localparam logic [7:0] ADI_OFS_PEND_HI = 8'h08;
    localparam logic [7:0] ADI_OFS_PEND_LO = 8'h09;
    localparam logic [7:0] ADI_OFS_VECTOR = 8'h0A;
    localparam logic [7:0] ADI_OFS_RESERVED = 8'h0B;
    localparam logic [7:0] ADI_OFS_GATE_HI = 8'h0C;
    localparam logic [7:0] ADI_OFS_GATE_LO = 8'h0D;

    // ========================================================
    // Source bit positions; vector code is position plus one
    localparam int ADI_SRC_SUPPLY_LOW = 0;
    localparam int ADI_SRC_OVERHEAT = 1;
    localparam int ADI_SRC_LIN_FAULT = 2;
    localparam int ADI_SRC_TIMER_CH0 = 3;
    localparam int ADI_SRC_TIMER_WRAP = 7;
    localparam int ADI_SRC_SERIAL_ERR = 8;
    localparam int ADI_SRC_SERIAL_TX = 9;
    localparam int ADI_SRC_SERIAL_RX = 10;
    localparam int ADI_SRC_MEASURE = 11;
    localparam int ADI_SRC_LIFETIME = 12;
    localparam int ADI_SRC_CAL = 13;
    localparam int ADI_LO_BITS = 6;

    // ========================================================
    // Reset values
    localparam logic [7:0] ADI_GATE_HI_RST = 8'h00;
    localparam logic [5:0] ADI_GATE_LO_RST = 6'h00;
    localparam logic [7:0] ADI_DATA_RST = 8'h00;
    localparam logic [4:0] ADI_VECT_NONE = 5'h00;

endpackage

// ==== hdl/adi_cond_latch.sv ====
/*
 * Pending latch for a condition-type source (supply low, overheat,
 * LIN fault). Sets on the rising edge of the live condition, clears on
 * an acknowledge only once the condition is gone.
 * Assumes cond is already synchronised and ack is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module adi_cond_latch (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Condition and control
    input wire logic cond,
    input wire logic arm,
    input wire logic force_set,
    input wire logic ack,
    // Result
    output logic pending
);
    logic cond_q;
    logic pend_q;
    logic pend_d;
    logic rise;

    // Only a fresh armed edge or force_set raises the source, so a lasting fault cannot re-fire
    assign rise = cond & ~cond_q & arm;
    // Set wins over a simultaneous acknowledge
    assign pend_d = rise | force_set | (pend_q & ~(ack & ~cond));
    assign pending = pend_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cond_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            cond_q <= cond;
            pend_q <= pend_d;
        end
    end

endmodule

`default_nettype wire

// ==== hdl/adi_prio_enc.sv ====
/*
 * Fixed-priority encoder: lowest pending bit wins and is reported as
 * its position plus one; zero when nothing is pending. Registered.
 * Assumes pend is a vector of pending levels on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module adi_prio_enc
    import adi_pkg::*;
#(
    parameter int N = ADI_NSRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pending sources
    input wire logic [N-1:0] pend,
    // Highest-priority code
    output logic [ADI_VW-1:0] code
);
    logic [ADI_VW-1:0] code_d;
    logic [ADI_VW-1:0] code_q;

    always_comb begin
        code_d = ADI_VECT_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                code_d = ADI_VW'(i + 1);
            end
        end
    end

    assign code = code_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_q <= ADI_VECT_NONE;
        end else begin
            code_q <= code_d;
        end
    end

endmodule

`default_nettype wire

// ==== hdl/adi_irq_agg.sv ====
/*
 * Analog-die interrupt aggregator: mirrors fourteen sources, reports the
 * top pending source number, gates each source with a global mask and
 * drives the die interrupt line.
 * Assumes an 8-bit register port from the die-to-die link on CLK and
 * source blocks on CLK; analog conditions arrive asynchronously.
 */
//
// Contract
// - Every pending analog-die event is signalled on one die interrupt line.
// - Mirror registers are read-only, one bit per source, showing pending state.
// - Reading the mirror has no side effect, clears nothing.
// - Vector register returns the number of the highest-priority pending source.
// - Reading the vector clears nothing; it follows pending sources only.
// - Two global mask registers, one bit per source, gate the interrupt line.
// - Supply-low acknowledged by write-one; stays while condition; re-arms on recurrence.
// - Supply-low flag shows the live condition, independent of the mirror.
// - With cranking mode on, supply-low alarm off; threshold enables precise detector.
// - Wake-up from cranking mode sets the supply-low indication.
// - Overheat acknowledged by write-one; live flag; re-arms only after recurrence.
// - LIN fault acknowledged by reading the LIN status register.
// - LIN fault stays while it persists; new interrupt needs cease and recur.
// - Measurement interrupt raised when voltage-done or current-done is set.
// - Lifetime interrupt raised on counter overflow with its enable set.
// - Calibration interrupt raised while a re-calibration request is present.
// - Registers reachable at offsets from base 0x0E00 and from 0x0F00.
// - Fourteen sources handled: supply, heat, LIN, timers, serial, measure, lifetime, calibration.
// - Vector reads zero when nothing is pending.
// - Fixed priority: supply-low code 0x01 highest, lower codes win.
`timescale 1ns/1ps
`default_nettype none

module adi_irq_agg (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register port from the die-to-die link
    input wire logic [adi_pkg::ADI_AW-1:0] ADDR,
    input wire logic RD_EN,
    input wire logic WR_EN,
    input wire logic [adi_pkg::ADI_DW-1:0] WR_DATA,
    output logic [adi_pkg::ADI_DW-1:0] RD_DATA,
    output logic RD_ACK,
    // Analog conditions, asynchronous
    input wire logic SUPPLY_LOW_COND,
    input wire logic OVERHEAT_COND,
    input wire logic LIN_FAULT_COND,
    // Acknowledge pulses from the power and LIN blocks
    input wire logic SUPPLY_LOW_FLAG_W1,
    input wire logic OVERHEAT_FLAG_W1,
    input wire logic LIN_STATUS_READ,
    // Cranking mode control
    input wire logic CRANK_EN,
    input wire logic LOW_POWER_MODE,
    input wire logic CRANK_WAKE,
    // Level requests from synchronous source blocks
    input wire logic [3:0] TIMER_CHAN_IRQ,
    input wire logic TIMER_WRAP_IRQ,
    input wire logic SERIAL_ERR_IRQ,
    input wire logic SERIAL_TX_IRQ,
    input wire logic SERIAL_RX_IRQ,
    input wire logic VOLTAGE_DONE_BIT,
    input wire logic CURRENT_DONE_BIT,
    input wire logic LIFETIME_OVERFLOW,
    input wire logic LIFETIME_IRQ_EN,
    input wire logic RECAL_REQUEST,
    // Outputs
    output logic DIE_IRQ_LINE,
    output logic SUPPLY_LOW_FLAG,
    output logic OVERHEAT_FLAG,
    output logic HP_LOW_VOLT_EN
);
    import adi_pkg::*;

    // ========================================================
    // Input synchronisers
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic sup_live;
    logic hot_live;
    logic lin_live;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_q <= 3'b000;
            sync_q <= 3'b000;
        end else begin
            meta_q <= {LIN_FAULT_COND, OVERHEAT_COND, SUPPLY_LOW_COND};
            sync_q <= meta_q;
        end
    end

    assign sup_live = sync_q[0];
    assign hot_live = sync_q[1];
    assign lin_live = sync_q[2];

    // ========================================================
    // Condition-type sources
    logic sup_pend;
    logic hot_pend;
    logic lin_pend;
    logic sup_arm;

    // Cranking mode silences the supply-low alarm
    assign sup_arm = ~CRANK_EN;

    adi_cond_latch u_supply (
        .clk(CLK),
        .resetn(RESETN),
        .cond(sup_live),
        .arm(sup_arm),
        .force_set(CRANK_WAKE),
        .ack(SUPPLY_LOW_FLAG_W1),
        .pending(sup_pend)
    );

    adi_cond_latch u_overheat (
        .clk(CLK),
        .resetn(RESETN),
        .cond(hot_live),
        .arm(1'b1),
        .force_set(1'b0),
        .ack(OVERHEAT_FLAG_W1),
        .pending(hot_pend)
    );

    adi_cond_latch u_lin (
        .clk(CLK),
        .resetn(RESETN),
        .cond(lin_live),
        .arm(1'b1),
        .force_set(1'b0),
        .ack(LIN_STATUS_READ),
        .pending(lin_pend)
    );

    // ========================================================
    // Pending vector, bit position plus one is the vector code
    logic [ADI_NSRC-1:0] pend;
    logic measure_pend;
    logic lifetime_pend;

    assign measure_pend = VOLTAGE_DONE_BIT | CURRENT_DONE_BIT;
    assign lifetime_pend = LIFETIME_OVERFLOW & LIFETIME_IRQ_EN;

    always_comb begin
        pend = '0;
        pend[ADI_SRC_SUPPLY_LOW] = sup_pend;
        pend[ADI_SRC_OVERHEAT] = hot_pend;
        pend[ADI_SRC_LIN_FAULT] = lin_pend;
        pend[ADI_SRC_TIMER_CH0 +: 4] = TIMER_CHAN_IRQ;
        pend[ADI_SRC_TIMER_WRAP] = TIMER_WRAP_IRQ;
        pend[ADI_SRC_SERIAL_ERR] = SERIAL_ERR_IRQ;
        pend[ADI_SRC_SERIAL_TX] = SERIAL_TX_IRQ;
        pend[ADI_SRC_SERIAL_RX] = SERIAL_RX_IRQ;
        pend[ADI_SRC_MEASURE] = measure_pend;
        pend[ADI_SRC_LIFETIME] = lifetime_pend;
        pend[ADI_SRC_CAL] = RECAL_REQUEST;
    end

    // ========================================================
    // Priority number
    logic [ADI_VW-1:0] top_code;

    // Registered, so the vector lags the sources by one cycle
    adi_prio_enc #(
        .N(ADI_NSRC)
    ) u_prio (
        .clk(CLK),
        .resetn(RESETN),
        .pend(pend),
        .code(top_code)
    );

    // ========================================================
    // Register decode
    logic [7:0] ofs;
    logic win_hit;
    logic sel_hi;
    logic sel_lo;
    logic sel_vec;
    logic sel_rsv;
    logic sel_ghi;
    logic sel_glo;
    logic known;

    assign ofs = ADDR[7:0];
    assign win_hit = (ADDR[15:8] == ADI_BASE_BLOCKING)
                   | (ADDR[15:8] == ADI_BASE_NONBLOCKING);
    assign sel_hi = win_hit & (ofs == ADI_OFS_PEND_HI);
    assign sel_lo = win_hit & (ofs == ADI_OFS_PEND_LO);
    assign sel_vec = win_hit & (ofs == ADI_OFS_VECTOR);
    assign sel_rsv = win_hit & (ofs == ADI_OFS_RESERVED);
    assign sel_ghi = win_hit & (ofs == ADI_OFS_GATE_HI);
    assign sel_glo = win_hit & (ofs == ADI_OFS_GATE_LO);
    assign known = sel_hi | sel_lo | sel_vec | sel_rsv | sel_ghi | sel_glo;

    // ========================================================
    // Global gate registers
    logic [7:0] gate_hi_q;
    logic [7:0] gate_hi_d;
    logic [5:0] gate_lo_q;
    logic [5:0] gate_lo_d;

    assign gate_hi_d = (WR_EN & sel_ghi) ? WR_DATA : gate_hi_q;
    assign gate_lo_d = (WR_EN & sel_glo) ? WR_DATA[ADI_LO_BITS-1:0] : gate_lo_q;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            gate_hi_q <= ADI_GATE_HI_RST;
            gate_lo_q <= ADI_GATE_LO_RST;
        end else begin
            gate_hi_q <= gate_hi_d;
            gate_lo_q <= gate_lo_d;
        end
    end

    // ========================================================
    // Read path; reads have no side effect on any source
    logic [7:0] rd_mux;
    logic [7:0] rd_data_d;
    logic rd_ack_d;
    logic [7:0] rd_data_q;
    logic rd_ack_q;

    always_comb begin
        rd_mux = ADI_DATA_RST;
        if (sel_hi) begin
            rd_mux = pend[7:0];
        end else if (sel_lo) begin
            rd_mux = {2'b00, pend[ADI_NSRC-1:8]};
        end else if (sel_vec) begin
            rd_mux = {3'b000, top_code};
        end else if (sel_ghi) begin
            rd_mux = gate_hi_q;
        end else if (sel_glo) begin
            rd_mux = {2'b00, gate_lo_q};
        end
    end

    assign rd_data_d = RD_EN ? rd_mux : rd_data_q;
    assign rd_ack_d = (RD_EN | WR_EN) & known;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_data_q <= ADI_DATA_RST;
            rd_ack_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_ack_q <= rd_ack_d;
        end
    end

    assign RD_DATA = rd_data_q;
    assign RD_ACK = rd_ack_q;

    // ========================================================
    // Interrupt line and live flags
    logic irq_d;
    logic irq_q;
    logic [2:0] flags_q;

    assign irq_d = |(pend & {gate_lo_q, gate_hi_q});

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_q <= 1'b0;
            flags_q <= 3'b000;
        end else begin
            irq_q <= irq_d;
            // Supply-low and overheat flags follow the live condition, not the latched source
            flags_q <= {CRANK_EN & LOW_POWER_MODE, hot_live, sup_live};
        end
    end

    assign DIE_IRQ_LINE = irq_q;
    assign SUPPLY_LOW_FLAG = flags_q[0];
    assign OVERHEAT_FLAG = flags_q[1];
    assign HP_LOW_VOLT_EN = flags_q[2];

endmodule

`default_nettype wire

// ==== testbench/adi_irq_agg_asserts.sv ====
/* Port checker for the interrupt aggregator.
   Assumes it is bound to the top module from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module adi_irq_agg_chk (
    // Clock, reset and register port
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [15:0] ADDR,
    input wire logic RD_EN,
    input wire logic WR_EN,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_ACK,
    // Sources and outputs
    input wire logic SUPPLY_LOW_COND,
    input wire logic OVERHEAT_COND,
    input wire logic CRANK_EN,
    input wire logic LOW_POWER_MODE,
    input wire logic [3:0] TIMER_CHAN_IRQ,
    input wire logic SUPPLY_LOW_FLAG,
    input wire logic OVERHEAT_FLAG,
    input wire logic HP_LOW_VOLT_EN
);
    // ==========================================================
    // Decode
    // High byte 0x0E or 0x0F, offsets 0x08..0x0D
    wire logic hit = ADDR[15:9] == 7'h07 && ADDR[7:0] >= 8'h08 && ADDR[7:0] <= 8'h0D;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_rd(o);
        RD_EN && hit && ADDR[7:0] == o;
    endsequence
    // ==========================================================
    // Register port
    property p_ack; (RD_EN || WR_EN) && hit |=> RD_ACK; endproperty
    a_ack: assert property (p_ack) else $error("no ack on mapped access");
    property p_miss; RD_EN && !hit |=> !RD_ACK && RD_DATA == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped read answered");
    property p_hold; !RD_EN |=> $stable(RD_DATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_vect; s_rd(8'h0A) |=> RD_DATA[7:5] == 3'b000; endproperty
    a_vect: assert property (p_vect) else $error("vector upper bits set");
    property p_lo; s_rd(8'h09) |=> RD_DATA[7:6] == 2'b00; endproperty
    a_lo: assert property (p_lo) else $error("mirror low upper bits set");
    property p_rsvd; s_rd(8'h0B) |=> RD_DATA == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved offset not zero");
    property p_mirror;
        s_rd(8'h08) ##0 $stable(TIMER_CHAN_IRQ) |=> RD_DATA[6:3] == $past(TIMER_CHAN_IRQ);
    endproperty
    a_mirror: assert property (p_mirror) else $error("timer bits not mirrored");
    // ==========================================================
    // Live flags and cranking
    property p_flag;
        $stable(SUPPLY_LOW_COND)[*4] |-> SUPPLY_LOW_FLAG == SUPPLY_LOW_COND;
    endproperty
    a_flag: assert property (p_flag) else $error("supply flag not live");
    property p_heat;
        $stable(OVERHEAT_COND)[*4] |-> OVERHEAT_FLAG == OVERHEAT_COND;
    endproperty
    a_heat: assert property (p_heat) else $error("overheat flag not live");
    property p_hplv; (CRANK_EN && LOW_POWER_MODE)[*2] |=> HP_LOW_VOLT_EN; endproperty
    a_hplv: assert property (p_hplv) else $error("precise detector not enabled");
endmodule
`default_nettype wire

// ==== testbench/adi_mcu_model.sv ====
/* Link-side model of the microcontroller making register accesses.
   Assumes the bench calls xfer; requests change on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module adi_mcu_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [15:0] addr,
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_ack
);
    initial begin
        addr = 16'h0000;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wr_data = 8'h00;
    end
    // ==========================================================
    // One access: held over the taking edge, answer one edge later
    task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q, output logic k);
        @(negedge clk);
        addr = a;
        rd_en = !w;
        wr_en = w;
        wr_data = d;
        @(posedge clk);
        // Acknowledge stands only for the cycle after the taking edge
        @(negedge clk);
        q = rd_data;
        k = rd_ack;
        rd_en = 1'b0;
        wr_en = 1'b0;
        // Inverse on release so a stale value never looks valid
        addr = ~a;
        wr_data = ~d;
    endtask
endmodule
`default_nettype wire

// ==== testbench/adi_irq_agg_tb.sv ====
/* Self-checking bench for the interrupt aggregator.
   Assumes the link model and the port checker beside the design. */
`timescale 1ns/1ps
`default_nettype none
module adi_irq_agg_tb;
    import adi_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] addr;
    logic rd_en, wr_en, rd_ack, irq, sflag, hflag, hplv, k;
    logic [7:0] wr_data, rd_data, q;
    logic [2:0] cnd = 3'b000;
    logic [2:0] ack = 3'b000;
    logic crank = 1'b0;
    logic lpm = 1'b0;
    logic wake = 1'b0;
    logic [12:0] r = 13'h0000;
    logic [13:0] gate, p;
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'h111c_f4cb;
    adi_irq_agg dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .RD_EN(rd_en),
        .WR_EN(wr_en), .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_ACK(rd_ack),
        .SUPPLY_LOW_COND(cnd[0]), .OVERHEAT_COND(cnd[1]), .LIN_FAULT_COND(cnd[2]),
        .SUPPLY_LOW_FLAG_W1(ack[0]), .OVERHEAT_FLAG_W1(ack[1]),
        .LIN_STATUS_READ(ack[2]), .CRANK_EN(crank), .LOW_POWER_MODE(lpm),
        .CRANK_WAKE(wake), .TIMER_CHAN_IRQ(r[3:0]), .TIMER_WRAP_IRQ(r[4]),
        .SERIAL_ERR_IRQ(r[5]), .SERIAL_TX_IRQ(r[6]), .SERIAL_RX_IRQ(r[7]),
        .VOLTAGE_DONE_BIT(r[8]), .CURRENT_DONE_BIT(r[9]), .LIFETIME_OVERFLOW(r[10]),
        .LIFETIME_IRQ_EN(r[11]), .RECAL_REQUEST(r[12]), .DIE_IRQ_LINE(irq),
        .SUPPLY_LOW_FLAG(sflag), .OVERHEAT_FLAG(hflag), .HP_LOW_VOLT_EN(hplv));
    adi_mcu_model mcu (.clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
        .wr_data(wr_data), .rd_data(rd_data), .rd_ack(rd_ack));
    initial forever #25 clk = ~clk;
    // ==========================================================
    // Expectations and helpers
    function automatic logic [13:0] pend_of(input logic [12:0] v);
        return {v[12], v[10] & v[11], v[8] | v[9], v[7:5], v[4], v[3:0], 3'b000};
    endfunction
    function automatic logic [7:0] vec_of(input logic [13:0] v);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 13; i >= 0; i--) if (v[i]) n = 8'(i + 1);
        return n;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] o, input logic [7:0] e, input string n);
        mcu.xfer({8'h0E, o}, 1'b0, 8'h00, q, k);
        chk(n, e, q);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        mcu.xfer(a, 1'b1, d, q, k);
    endtask
    task automatic pulse(input int j);
        @(negedge clk) ack[j] = 1'b1;
        @(negedge clk) ack[j] = 1'b0;
    endtask
    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        err_count++;
        give_verdict();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        for (int o = 8; o < 14; o++) rd(8'(o), 8'h00, "reset value");
        wr(16'h0F0D, 8'hFF);
        chk("write ack", 8'h01, {7'h00, k});
        rd(8'h0D, 8'h3F, "gate low");
        wr(16'h0E08, 8'hFF);
        wr(16'h0E0B, 8'hFF);
        rd(8'h08, 8'h00, "read-only");
        rd(8'h0B, 8'h00, "reserved");
        wr(16'h0D0D, 8'h00);
        rd(8'h0D, 8'h3F, "gate after miss");
        mcu.xfer(16'h0E0E, 1'b0, 8'h00, q, k);
        chk("unmapped", 8'h00, {k, q[6:0]});
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            r = 13'($random(seed));
            if (i < 13) r = 13'h0001 << i;
            gate = 14'($random(seed));
            p = pend_of(r);
            wr(16'h0F0C, gate[7:0]);
            wr(16'h0F0D, {2'b00, gate[13:8]});
            rd(8'h0C, gate[7:0], "gate high");
            rd(8'h08, p[7:0], "mirror high");
            rd(8'h09, {2'b00, p[13:8]}, "mirror low");
            rd(8'h0A, vec_of(p), "vector");
            rd(8'h0A, vec_of(p), "vector again");
            chk("line", {7'h00, |(p & gate)}, {7'h00, irq});
        end
        @(negedge clk) r = 13'h0000;
        wr(16'h0E0C, 8'h07);
        for (int j = 0; j < 3; j++) begin
            @(negedge clk) cnd[j] = 1'b1;
            repeat (5) @(negedge clk);
            rd(8'h0A, 8'(j + 1), "cond vector");
            chk("flags", {6'h00, j == 1, j == 0}, {6'h00, hflag, sflag});
            chk("precise idle", 8'h00, {7'h00, hplv});
            chk("cond line", 8'h01, {7'h00, irq});
            pulse(j);
            rd(8'h08, 8'h01 << j, "ack while present");
            @(negedge clk) cnd[j] = 1'b0;
            repeat (5) @(negedge clk);
            chk("flags clear", 8'h00, {6'h00, hflag, sflag});
            rd(8'h08, 8'h01 << j, "latched");
            pulse(j);
            rd(8'h08, 8'h00, "acked");
            chk("line off", 8'h00, {7'h00, irq});
        end
        @(negedge clk) crank = 1'b1;
        lpm = 1'b1;
        cnd[0] = 1'b1;
        repeat (5) @(negedge clk);
        rd(8'h08, 8'h00, "cranking");
        chk("precise enable", 8'h01, {7'h00, hplv});
        cnd[0] = 1'b0;
        wake = 1'b1;
        @(negedge clk) wake = 1'b0;
        rd(8'h0A, 8'h01, "crank wake");
        pulse(0);
        rd(8'h08, 8'h00, "crank acked");
        @(negedge clk) resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd(8'h0C, 8'h00, "gate after reset");
        give_verdict();
    end
endmodule
bind adi_irq_agg adi_irq_agg_chk u_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
    .RD_EN(RD_EN), .WR_EN(WR_EN), .RD_DATA(RD_DATA), .RD_ACK(RD_ACK),
    .SUPPLY_LOW_COND(SUPPLY_LOW_COND), .OVERHEAT_COND(OVERHEAT_COND),
    .CRANK_EN(CRANK_EN), .LOW_POWER_MODE(LOW_POWER_MODE),
    .TIMER_CHAN_IRQ(TIMER_CHAN_IRQ), .SUPPLY_LOW_FLAG(SUPPLY_LOW_FLAG),
    .OVERHEAT_FLAG(OVERHEAT_FLAG), .HP_LOW_VOLT_EN(HP_LOW_VOLT_EN));
`default_nettype wire
